// [src/gom_output_mux.sv]
module gom_output_mux
	import gom_pkg::*;
(
	input  wire logic        i_mclk,
	input  wire logic        i_rst_b,
	input  wire logic        i_wr_en,
	input  wire logic [7:0]  i_wr_addr,
	input  wire logic [7:0]  i_wr_data,
	input  wire logic [7:0]  i_rd_addr,
	output logic      [7:0]  o_rd_data,
	input  wire logic [3:0]  i_port0_remote_pins,
	input  wire logic [3:0]  i_port1_remote_pins,
	input  wire logic [1:0]  i_port_lock,
	input  wire logic [1:0]  i_port_pass,
	input  wire logic [1:0]  i_port_enabled,
	input  wire logic        i_frame_sync_pulse,
	output logic      [1:0]  o_pin_out,
	output logic      [1:0]  o_pin_oe
);
	// every pin-side input is from another domain: two-stage sync
	localparam int SYNC_W = 15;
	logic [SYNC_W-1:0] meta_d;
	logic [SYNC_W-1:0] sync_d;
	logic [SYNC_W-1:0] meta_q;
	logic [SYNC_W-1:0] sync_q;
	logic [SYNC_W-1:0] raw;
	logic [3:0]        rp0;
	logic [3:0]        rp1;
	logic [1:0]        lock_s;
	logic [1:0]        pass_s;
	logic [1:0]        ena_s;
	logic              fsync_s;

	assign raw = {
		i_frame_sync_pulse,
		i_port_enabled,
		i_port_pass,
		i_port_lock,
		i_port1_remote_pins,
		i_port0_remote_pins
	};
	assign rp0     = sync_q[3:0];
	assign rp1     = sync_q[7:4];
	assign lock_s  = sync_q[9:8];
	assign pass_s  = sync_q[11:10];
	assign ena_s   = sync_q[13:12];
	assign fsync_s = sync_q[14];

	// only the second stage reads the first
	always_comb
	begin
		meta_d = raw;
		sync_d = meta_q;
	end

	// cleared in reset so no false lock shows on release
	always_ff @(posedge i_mclk)
	begin
		if (!i_rst_b)
		begin
			meta_q <= {SYNC_W{1'b0}};
			sync_q <= {SYNC_W{1'b0}};
		end
		else
		begin
			meta_q <= meta_d;
			sync_q <= sync_d;
		end
	end

	// combined status over enabled ports only; no enabled port gives and-terms low
	logic lock_or;
	logic lock_and;
	logic pass_and;
	assign lock_or  = |(lock_s & ena_s);
	assign lock_and = (|ena_s) & (&(lock_s | ~ena_s));
	assign pass_and = (|ena_s) & (&(pass_s | ~ena_s));

	logic [7:0] ctl_q [NUM_PINS];
	logic [7:0] ctl_d [NUM_PINS];
	logic [1:0] out_d;
	logic [1:0] oe_d;
	logic [1:0] out_q;
	logic [1:0] oe_q;
	logic [7:0] rd_d;
	logic [7:0] rd_q;

	// pins registered: no decode glitch reaches the board
	genvar g;
	generate
		for (g = 0; g < NUM_PINS; g++)
		begin : g_pin
			localparam logic [7:0] ADDR = (g == 0) ? PIN1_CTL_ADDR : PIN2_CTL_ADDR;
			logic [2:0] src;
			logic [2:0] sel;
			logic [3:0] rpins;
			logic       pv;
			logic       wr_hit;
			logic       pt_lock;
			logic       pt_pass;
			assign src     = ctl_q[g][SRC_HI:SRC_LO];
			assign sel     = ctl_q[g][SEL_HI:SEL_LO];
			assign wr_hit  = i_wr_en && (i_wr_addr == ADDR);
			// port 1 only for its own code, else port 0
			assign pt_lock = (src == SRC_PORT1) ? lock_s[1] : lock_s[0];
			assign pt_pass = (src == SRC_PORT1) ? pass_s[1] : pass_s[0];

			always_comb
			begin
				ctl_d[g] = ctl_q[g];
				if (wr_hit)
				begin
					ctl_d[g] = i_wr_data;
				end
			end

			always_comb
			begin
				pv    = 1'b0;
				rpins = (src == SRC_PORT1) ? rp1 : rp0;
				if ((src == SRC_PORT0) || (src == SRC_PORT1))
				begin
					if (sel < RSEL_LOCK)
					begin
						pv = rpins[sel[1:0]];
					end
					else if (sel == RSEL_LOCK)
					begin
						pv = pt_lock;
					end
					else if (sel == RSEL_PASS)
					begin
						pv = pt_pass;
					end
					else
					begin
						pv = 1'b0;
					end
				end
				else if (src == SRC_STATUS)
				begin
					case (sel)
						DSEL_VALUE:    pv = ctl_q[g][VAL_BIT];
						DSEL_LOCK_OR:  pv = lock_or;
						DSEL_LOCK_AND: pv = lock_and;
						DSEL_PASS_AND: pv = pass_and;
						DSEL_FSYNC:    pv = fsync_s;
						default:       pv = 1'b0;
					endcase
				end
				else
				begin
					pv = 1'b0;
				end
				out_d[g] = ctl_q[g][EN_BIT] & pv;
				oe_d[g]  = ctl_q[g][EN_BIT];
			end

			always_ff @(posedge i_mclk)
			begin
				if (!i_rst_b)
				begin
					ctl_q[g] <= CTL_RESET;
					out_q[g] <= 1'b0;
					oe_q[g]  <= 1'b0;
				end
				else
				begin
					ctl_q[g] <= ctl_d[g];
					out_q[g] <= out_d[g];
					oe_q[g]  <= oe_d[g];
				end
			end
		end
	endgenerate

	// registered read port, unmapped reads zero
	always_comb
	begin
		if (i_rd_addr == PIN1_CTL_ADDR)
		begin
			rd_d = ctl_q[0];
		end
		else if (i_rd_addr == PIN2_CTL_ADDR)
		begin
			rd_d = ctl_q[1];
		end
		else
		begin
			rd_d = 8'h00;
		end
	end

	// registered so read data comes straight from a flop
	always_ff @(posedge i_mclk)
	begin
		if (!i_rst_b)
		begin
			rd_q <= 8'h00;
		end
		else
		begin
			rd_q <= rd_d;
		end
	end

	assign o_rd_data = rd_q;
	assign o_pin_out = out_q;
	assign o_pin_oe  = oe_q;
endmodule

// [include/gom_pkg.sv]
package gom_pkg;
	localparam int          NUM_PINS       = 2;
	localparam int          NUM_PORTS      = 2;
	localparam int          REG_W          = 8;
	localparam logic [7:0]  PIN1_CTL_ADDR  = 8'h11;
	localparam logic [7:0]  PIN2_CTL_ADDR  = 8'h12;
	localparam logic [7:0]  CTL_RESET      = 8'h00;
	localparam int          SEL_HI         = 7;
	localparam int          SEL_LO         = 5;
	localparam int          SRC_HI         = 4;
	localparam int          SRC_LO         = 2;
	localparam int          VAL_BIT        = 1;
	localparam int          EN_BIT         = 0;
	localparam logic [2:0]  SRC_PORT0      = 3'h0;
	localparam logic [2:0]  SRC_PORT1      = 3'h1;
	localparam logic [2:0]  SRC_STATUS     = 3'h4;
	localparam logic [2:0]  RSEL_LOCK      = 3'h4;
	localparam logic [2:0]  RSEL_PASS      = 3'h5;
	localparam logic [2:0]  DSEL_VALUE     = 3'h0;
	localparam logic [2:0]  DSEL_LOCK_OR   = 3'h1;
	localparam logic [2:0]  DSEL_LOCK_AND  = 3'h2;
	localparam logic [2:0]  DSEL_PASS_AND  = 3'h3;
	localparam logic [2:0]  DSEL_FSYNC     = 3'h4;
endpackage

// [sim/gom_output_mux_assertions.sv]
module gom_output_mux_assertions
	import gom_pkg::*;
(
	input wire logic       i_mclk,
	input wire logic       i_rst_b,
	input wire logic       i_wr_en,
	input wire logic [7:0] i_wr_addr,
	input wire logic [7:0] i_wr_data,
	input wire logic [1:0] i_port_lock,
	input wire logic [1:0] o_pin_out,
	input wire logic [1:0] o_pin_oe
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge i_mclk); endclocking
	default disable iff (!i_rst_b);
	sequence w1_s;
		i_wr_en && i_wr_addr == PIN1_CTL_ADDR;
	endsequence
	sequence w2_s;
		i_wr_en && i_wr_addr == PIN2_CTL_ADDR;
	endsequence
	idle_low_a:
		assert property ((o_pin_out & ~o_pin_oe) == 2'h0) else $error("driven while off");
	en_two_a:
		assert property (w2_s |-> ##2 o_pin_oe[1] == $past(i_wr_data[0], 2)) else $error("pin2 enable");
	local_value_a:
		assert property (w1_s ##0 i_wr_data[7:2] == 6'h04 && i_wr_data[0] |-> ##2 o_pin_out[0] == $past(i_wr_data[1], 2))
		else $error("pin1 value");
	rsv_src_a:
		assert property (w2_s ##0 i_wr_data[4:3] == 2'h1 |-> ##2 !o_pin_out[1]) else $error("pin2 reserved");
	rsv_sel_a:
		assert property (w1_s ##0 i_wr_data[7:6] == 2'h3 |-> ##2 !o_pin_out[0]) else $error("pin1 reserved");
	port_lock_a:
		assert property (w1_s ##0 i_wr_data == 8'h81 ##0 $stable(i_port_lock[0]) [*3] |-> o_pin_out[0] == i_port_lock[0])
		else $error("pin1 lock");
endmodule
bind gom_output_mux gom_output_mux_assertions chk_i (.*);

// [sim/gom_board_model.sv]
module gom_board_model
(
	input  wire logic       i_mclk,
	input  wire logic [1:0] i_pin_out,
	input  wire logic [1:0] i_pin_oe,
	output logic      [1:0] o_level_q
);
	timeunit 1ns;
	timeprecision 1ps;
	// undriven pin reads low through the board pull-down
	always_ff @(posedge i_mclk)
	begin
		o_level_q <= i_pin_out & i_pin_oe;
	end
endmodule

// [sim/tb_top.sv]
module tb_top
	import gom_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic        i_mclk, i_rst_b, i_wr_en, i_frame_sync_pulse;
	logic [7:0]  i_wr_addr, i_wr_data, i_rd_addr, o_rd_data, c1, c2;
	logic [3:0]  i_port0_remote_pins, i_port1_remote_pins;
	logic [1:0]  i_port_lock, i_port_pass, i_port_enabled, o_pin_out, o_pin_oe, lvl, ep;
	logic [31:0] rs;
	logic [7:0]  cor [8] = '{8'h81, 8'h13, 8'h11, 8'h09, 8'hE1, 8'hB1, 8'h91, 8'h51};
	int          fail_count, comparisons;
	gom_output_mux dut (.*);
	gom_board_model brd (.i_mclk(i_mclk), .i_pin_out(o_pin_out), .i_pin_oe(o_pin_oe), .o_level_q(lvl));
	initial
	begin
		i_mclk = 1'b0;
		forever #20 i_mclk = ~i_mclk;
	end
	function automatic logic ex(input logic [7:0] c);
		logic [2:0] s;
		s = c[7:5];
		if (!c[0] || c[4:3] == 2'h1 || c[4:2] > 3'h4)
			return 1'b0;
		if (c[4:2] != SRC_STATUS)
			return s < 3'h4 ? (c[2] ? i_port1_remote_pins[s[1:0]] : i_port0_remote_pins[s[1:0]]) :
				s == 3'h4 ? i_port_lock[c[2]] : s == 3'h5 ? i_port_pass[c[2]] : 1'b0;
		case (s)
			3'h0: return c[1];
			3'h1: return |(i_port_lock & i_port_enabled);
			3'h2: return i_port_enabled != 2'h0 && (i_port_lock & i_port_enabled) == i_port_enabled;
			3'h3: return i_port_enabled != 2'h0 && (i_port_pass & i_port_enabled) == i_port_enabled;
			3'h4: return i_frame_sync_pulse;
			default: return 1'b0;
		endcase
	endfunction
	function automatic logic [31:0] lfsr_next(input logic [31:0] v);
		return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
	endfunction
	task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
		comparisons++;
		if (g !== e)
		begin
			fail_count++;
			$display("CHECK FAILED %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		{i_wr_en, i_wr_addr, i_wr_data} = {1'b1, a, d};
		@(posedge i_mclk) #1;
		i_wr_en = 1'b0;
		@(posedge i_mclk) #1;
	endtask
	task automatic rdc(input logic [7:0] a, input logic [7:0] e);
		i_rd_addr = a;
		@(posedge i_mclk) #1;
		chk("read data", e, o_rd_data);
	endtask
	task automatic report_and_stop();
		$display("comparisons %0d fail_count %0d", comparisons, fail_count);
		if (fail_count == 0 && comparisons > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	initial
	begin
		{i_rst_b, i_wr_en, i_frame_sync_pulse, i_wr_addr, i_wr_data, i_rd_addr} = 27'h0;
		{i_port0_remote_pins, i_port1_remote_pins, i_port_lock, i_port_pass, i_port_enabled} = 14'h0;
		rs = 32'd74486;
		repeat (4) @(posedge i_mclk);
		#1 i_rst_b = 1'b1;
		chk("pin enable", 8'h00, {6'h0, o_pin_oe});
		rdc(PIN2_CTL_ADDR, CTL_RESET);
		for (int i = 0; i < 72; i++)
		begin
			rs = lfsr_next(rs);
			{i_port0_remote_pins, i_port1_remote_pins, i_port_lock, i_port_pass, i_port_enabled} = rs[31:18];
			i_frame_sync_pulse = rs[17];
			c1 = i < 8 ? cor[i] : rs[7:0];
			c2 = i < 8 ? cor[7 - i] : rs[15:8];
			// inputs settle a cycle before the write
			@(posedge i_mclk) #1;
			wr(PIN1_CTL_ADDR, c1);
			wr(PIN2_CTL_ADDR, c2);
			repeat (4) @(posedge i_mclk);
			#1 ep = {ex(c2), ex(c1)};
			chk("pin out", {6'h0, ep}, {6'h0, o_pin_out});
			chk("board level", {6'h0, ep}, {6'h0, lvl});
			chk("pin enable", {6'h0, c2[0], c1[0]}, {6'h0, o_pin_oe});
			rdc(PIN1_CTL_ADDR, c1);
			rdc(PIN2_CTL_ADDR, c2);
			rdc(8'h13, 8'h00);
		end
		report_and_stop();
	end
endmodule
